// *** inc/daqreg_pkg.sv ***
// Package with offsets, field positions, depths and codes of the DAQ register bank.
package daqreg_pkg;
  localparam int ADDR_W = 5;
  localparam logic [4:0] OFS_ACQ_CLEAR = 5'h01;
  localparam logic [4:0] OFS_RESULT_FIFO = 5'h02;
  localparam logic [4:0] OFS_TIMER_IRQ_CLEAR = 5'h06;
  localparam logic [4:0] OFS_COUNTER0_DATA = 5'h08;
  localparam logic [4:0] OFS_COUNTER1_DATA = 5'h09;
  localparam logic [4:0] OFS_COUNTER2_DATA = 5'h0A;
  localparam logic [4:0] OFS_COUNTER_MODE = 5'h0B;
  localparam int CONV_W = 12;
  localparam int WORD_W = 16;
  localparam int RESULT_DEPTH = 512;
  localparam int RESULT_AW = 9;
  localparam int STAGE_DEPTH = 8;
  localparam int STAGE_AW = 3;
  localparam int NUM_COUNTERS = 3;
  localparam int SC_MSB = 7;
  localparam int SC_LSB = 6;
  localparam int RL_MSB = 5;
  localparam int RL_LSB = 4;
  localparam int MODE_MSB = 3;
  localparam int MODE_LSB = 1;
  localparam int BCD_BIT = 0;
  localparam int RB_NOCOUNT_BIT = 5;
  localparam int RB_SEL_LSB = 1;
  localparam logic [1:0] SC_READBACK = 2'h3;
  localparam logic [1:0] RL_LATCH = 2'h0;
  localparam logic [1:0] RL_LOW = 2'h1;
  localparam logic [1:0] RL_HIGH = 2'h2;
  localparam logic [1:0] RL_LOW_HIGH = 2'h3;
  localparam logic [2:0] MODE_TERM_IRQ = 3'h0;
  localparam logic [2:0] MODE_ONE_SHOT = 3'h1;
  localparam logic [2:0] MODE_RATE = 3'h2;
  localparam logic [2:0] MODE_SQUARE = 3'h3;
  localparam logic [2:0] MODE_SW_STROBE = 3'h4;
  localparam logic [2:0] MODE_HW_STROBE = 3'h5;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] READ_IDLE = 16'h0000;
endpackage

// *** logic/daqreg_bank.sv ***
// Result FIFO, conversion staging buffer and counter register bank.
`timescale 1ns/100ps

// Plain FIFO; pointers and count are registers, flags decode the count, the flush empties it.
module daqreg_fifo #(
  parameter int W = 16,
  parameter int D = 8,
  parameter int AW = 3
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic [W-1:0] mem [D];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  logic [AW:0] cnt_nxt;
  logic push;
  logic pop;
  assign in_ready = (cnt_r != D[AW:0]);
  assign out_valid = (cnt_r != '0);
  assign out_data = mem[rp_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign cnt_nxt = cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else if (flush) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      if (push) wp_r <= AW'(wp_r + 1'b1);
      if (pop) rp_r <= AW'(rp_r + 1'b1);
      cnt_r <= cnt_nxt;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (push && !flush) mem[wp_r] <= in_data;
  end
endmodule

// What this block does
// (R1) Sign-extend results, keep 512 words plus 8 staged, 520 in all.
// (R2) Result port read pops oldest word.
// (R3) Data-available flag means FIFO not empty.
// (R4) Host checks status before each FIFO read.
// (R5) Results span -2048..2047, sign in 15..11.
// (R6) Clear write empties, reloads last value, clears errors.
// (R7) Host discards one word after a clear.
// (R8) Three 16-bit counters, one mode register.
// (R9) Counter 0 output paces conversions.
// (R10) Timer clear write drops counter 2 request.
// (R11) Ports 08-0A load and read counters.
// (R12) Mode register fields: select, access, mode, format.
// (R13) Select codes pick counter or read-back.
// (R14) Access: latch, low, high, low-then-high.
// (R15) Latch command freezes count for next read.
// (R16) Six counting modes chosen by mode field.
// (R17) Format bit selects BCD or binary counting.
// (R18) Clear sets data-available; a read clears it.
// (R19) Flag FIFO overflow and conversion overrun.
// (R20) Low-then-high alternates, restarts at low.
module daqreg_bank (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [daqreg_pkg::ADDR_W-1:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [daqreg_pkg::WORD_W-1:0] bus_rdata,
  input wire logic adc_valid,
  input wire logic [daqreg_pkg::CONV_W-1:0] adc_data,
  output logic adc_ready,
  input wire logic adc_busy,
  output logic conv_start,
  input wire logic [daqreg_pkg::NUM_COUNTERS-1:0] counter_clk,
  input wire logic [daqreg_pkg::NUM_COUNTERS-1:0] counter_gate,
  output logic [daqreg_pkg::NUM_COUNTERS-1:0] counter_out,
  output logic data_available_flag,
  output logic overflow_flag,
  output logic overrun_flag,
  output logic timer_irq_flag
);
  import daqreg_pkg::*;

  function automatic logic [15:0] sign_extend(input logic [11:0] v);
    sign_extend = {{4{v[11]}}, v};
  endfunction

  // Decrement by one, digit-wise when counting in BCD; zero wraps.
  function automatic logic [15:0] count_down(input logic [15:0] v,
                                             input logic bcd);
    logic [15:0] r;
    logic borrow;
    r = v - 16'h0001;
    borrow = 1'b1;
    if (bcd) begin
      for (int d = 0; d < 4; d++) begin
        if (borrow) begin
          if (v[4*d +: 4] == 4'h0) begin
            r[4*d +: 4] = 4'h9;
          end else begin
            r[4*d +: 4] = v[4*d +: 4] - 4'h1;
            borrow = 1'b0;
          end
        end else begin
          r[4*d +: 4] = v[4*d +: 4];
        end
      end
    end
    count_down = r;
  endfunction

  logic stage_ready;
  logic stage_valid;
  logic [WORD_W-1:0] stage_data;
  logic stage_pop;
  logic res_in_valid;
  logic res_ready;
  logic [WORD_W-1:0] res_in_data;
  logic res_valid;
  logic [WORD_W-1:0] res_data;
  logic res_pop;
  logic [CONV_W-1:0] last_conv_r;
  logic clr_pend_r;
  logic [WORD_W-1:0] bus_rdata_r;
  logic adc_ready_r;
  logic conv_start_r;
  logic data_avail_r;
  logic overflow_r;
  logic overrun_r;
  logic timer_irq_r;
  logic cnt0_out_d_r;
  logic cnt2_out_d_r;
  logic [NUM_COUNTERS-1:0] out_w;
  logic [7:0] rd_byte_w [NUM_COUNTERS];
  logic [7:0] rd_counter_byte;

  wire wr_clear = bus_wr && (bus_addr == OFS_ACQ_CLEAR);
  wire rd_fifo = bus_rd && (bus_addr == OFS_RESULT_FIFO);
  wire wr_tclr = bus_wr && (bus_addr == OFS_TIMER_IRQ_CLEAR);
  wire wr_mode = bus_wr && (bus_addr == OFS_COUNTER_MODE);
  wire [1:0] sc_field = bus_wdata[SC_MSB:SC_LSB];
  wire [1:0] rl_field = bus_wdata[RL_MSB:RL_LSB];
  wire is_readback = wr_mode && (sc_field == SC_READBACK); // [R13]
  wire conv_edge = counter_out[0] && !cnt0_out_d_r;
  wire cnt2_rise = counter_out[2] && !cnt2_out_d_r;

  // Staging buffer absorbs bursts; a full result FIFO stalls it.
  daqreg_fifo #(.W(WORD_W), .D(STAGE_DEPTH), .AW(STAGE_AW)) u_stage (
    .sys_clk(sys_clk),
    .reset(reset),
    .flush(wr_clear),
    .in_valid(adc_valid),
    .in_ready(stage_ready),
    .in_data(sign_extend(adc_data)), // [R1] [R5]
    .out_valid(stage_valid),
    .out_ready(stage_pop),
    .out_data(stage_data)
  );

  // The clear reload takes the result FIFO's write side for one cycle.
  assign stage_pop = res_ready && !clr_pend_r;
  assign res_in_valid = clr_pend_r || stage_valid;
  assign res_in_data = clr_pend_r ? sign_extend(last_conv_r) :
                       stage_data; // [R6]
  assign res_pop = rd_fifo && res_valid; // [R2]

  daqreg_fifo #(.W(WORD_W), .D(RESULT_DEPTH), .AW(RESULT_AW)) u_result (
    .sys_clk(sys_clk),
    .reset(reset),
    .flush(wr_clear), // [R6]
    .in_valid(res_in_valid),
    .in_ready(res_ready),
    .in_data(res_in_data),
    .out_valid(res_valid),
    .out_ready(res_pop),
    .out_data(res_data)
  );

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      last_conv_r <= '0;
      clr_pend_r <= 1'b0;
    end else begin
      if (adc_valid) last_conv_r <= adc_data;
      clr_pend_r <= wr_clear; // [R6]
    end
  end

  // Error flags: a new event in the clear cycle still sets the flag.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      overflow_r <= 1'b0;
      overrun_r <= 1'b0;
      timer_irq_r <= 1'b0;
    end else begin
      overflow_r <= (adc_valid && !stage_ready) ||
                    (overflow_r && !wr_clear); // [R19] [R6]
      overrun_r <= (conv_edge && adc_busy) ||
                   (overrun_r && !wr_clear); // [R19] [R6]
      timer_irq_r <= cnt2_rise || (timer_irq_r && !wr_tclr); // [R10]
    end
  end

  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      data_avail_r <= 1'b0;
      adc_ready_r <= 1'b0;
      conv_start_r <= 1'b0;
      cnt0_out_d_r <= 1'b1;
      cnt2_out_d_r <= 1'b1;
    end else begin
      data_avail_r <= res_valid || clr_pend_r; // [R3] [R18]
      adc_ready_r <= stage_ready;
      conv_start_r <= conv_edge; // [R9]
      cnt0_out_d_r <= counter_out[0];
      cnt2_out_d_r <= counter_out[2];
    end
  end

  assign rd_counter_byte =
    (bus_addr == OFS_COUNTER0_DATA) ? rd_byte_w[0] :
    (bus_addr == OFS_COUNTER1_DATA) ? rd_byte_w[1] : rd_byte_w[2];

  // Reads answer one cycle after the strobe; unmapped offsets read zero.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bus_rdata_r <= READ_IDLE;
    end else if (rd_fifo) begin
      bus_rdata_r <= res_data; // [R2]
    end else if (bus_rd && bus_addr >= OFS_COUNTER0_DATA &&
                 bus_addr <= OFS_COUNTER2_DATA) begin
      bus_rdata_r <= {8'h00, rd_counter_byte}; // [R11]
    end else if (bus_rd) begin
      bus_rdata_r <= READ_IDLE;
    end
  end

  for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
    logic [15:0] cnt_r;
    logic [15:0] reload_r;
    logic [15:0] latch_r;
    logic [2:0] mode_r;
    logic [1:0] rl_r;
    logic bcd_r;
    logic latched_r;
    logic wr_hi_r;
    logic rd_hi_r;
    logic start_r;
    logic running_r;
    logic out_r;
    logic clk_d_r;
    logic gate_d_r;
    wire sel_port = (bus_addr == OFS_COUNTER0_DATA + 5'(i));
    wire wr_port = bus_wr && sel_port;
    wire rd_port = bus_rd && sel_port;
    wire mode_here = wr_mode && (sc_field == 2'(i)); // [R13]
    wire latch_cmd = (mode_here && rl_field == RL_LATCH) ||
                     (is_readback && !bus_wdata[RB_NOCOUNT_BIT] &&
                      bus_wdata[RB_SEL_LSB + i]); // [R15]
    wire new_mode = mode_here && rl_field != RL_LATCH;
    wire [2:0] m_eff = mode_r[1] ? {1'b0, mode_r[1:0]} : mode_r;
    wire hw_trig = (m_eff == MODE_ONE_SHOT) || (m_eff == MODE_HW_STROBE);
    wire tick = counter_clk[i] && !clk_d_r;
    wire gate_rise = counter_gate[i] && !gate_d_r;
    wire gate_ok = hw_trig || counter_gate[i];
    wire hi_phase = (rl_r == RL_HIGH) ||
                    (rl_r == RL_LOW_HIGH && rd_hi_r); // [R14]
    wire load_done = wr_port && !(rl_r == RL_LOW_HIGH && !wr_hi_r);
    wire read_done = rd_port && !(rl_r == RL_LOW_HIGH && !rd_hi_r);
    wire [15:0] view = latched_r ? latch_r : cnt_r; // [R15]
    wire [15:0] dec = count_down(cnt_r, bcd_r); // [R17]
    assign rd_byte_w[i] = hi_phase ? view[15:8] : view[7:0];
    assign out_w[i] = out_r;

    // Mode and access state; byte pointers restart at the low byte.
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        mode_r <= MODE_TERM_IRQ;
        rl_r <= RL_LOW_HIGH;
        bcd_r <= 1'b0;
        wr_hi_r <= 1'b0;
        rd_hi_r <= 1'b0;
        reload_r <= COUNT_RESET;
        latch_r <= COUNT_RESET;
        latched_r <= 1'b0;
      end else begin
        if (new_mode) begin
          mode_r <= bus_wdata[MODE_MSB:MODE_LSB]; // [R12] [R16]
          rl_r <= rl_field; // [R14]
          bcd_r <= bus_wdata[BCD_BIT]; // [R17]
          wr_hi_r <= 1'b0; // [R20]
          rd_hi_r <= 1'b0; // [R20]
          latched_r <= 1'b0;
        end else begin
          if (wr_port && rl_r == RL_LOW_HIGH) wr_hi_r <= !wr_hi_r; // [R20]
          if (rd_port && rl_r == RL_LOW_HIGH) rd_hi_r <= !rd_hi_r; // [R20]
          if (wr_port) begin
            if (rl_r == RL_HIGH || (rl_r == RL_LOW_HIGH && wr_hi_r))
              reload_r[15:8] <= bus_wdata; // [R11]
            else
              reload_r[7:0] <= bus_wdata; // [R11]
          end
          if (latch_cmd && !latched_r) begin
            latch_r <= cnt_r; // [R15]
            latched_r <= 1'b1;
          end else if (read_done) begin
            latched_r <= 1'b0;
          end
        end
      end
    end

    // Counting engine, advanced on each rising edge of the counter clock.
    always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
        cnt_r <= COUNT_RESET;
        start_r <= 1'b0;
        running_r <= 1'b0;
        out_r <= 1'b1;
        clk_d_r <= 1'b0;
        gate_d_r <= 1'b0;
      end else begin
        clk_d_r <= counter_clk[i];
        gate_d_r <= counter_gate[i];
        if (new_mode) begin
          start_r <= 1'b0;
          running_r <= 1'b0;
          out_r <= (bus_wdata[MODE_MSB:MODE_LSB] != MODE_TERM_IRQ);
        end else if ((load_done && !hw_trig) || (gate_rise && hw_trig)) begin
          start_r <= 1'b1; // [R16]
          if (m_eff == MODE_TERM_IRQ) out_r <= 1'b0;
        end else if (tick && start_r) begin
          cnt_r <= reload_r;
          start_r <= 1'b0;
          running_r <= 1'b1;
          if (m_eff == MODE_ONE_SHOT) out_r <= 1'b0;
        end else if (tick && running_r && gate_ok) begin
          cnt_r <= dec; // [R8]
          case (m_eff)
            MODE_TERM_IRQ, MODE_ONE_SHOT: begin
              if (cnt_r == 16'h0001) out_r <= 1'b1;
            end
            MODE_RATE: begin
              out_r <= (cnt_r != 16'h0002);
              if (cnt_r == 16'h0001) cnt_r <= reload_r;
            end
            MODE_SQUARE: begin
              out_r <= (dec > {1'b0, reload_r[15:1]});
              if (cnt_r == 16'h0001) cnt_r <= reload_r;
            end
            default: begin
              out_r <= (cnt_r != 16'h0001);
              if (cnt_r == 16'h0000) running_r <= 1'b0;
            end
          endcase
        end
      end
    end
  end

  assign bus_rdata = bus_rdata_r;
  assign adc_ready = adc_ready_r;
  assign conv_start = conv_start_r;
  assign counter_out = out_w;
  assign data_available_flag = data_avail_r;
  assign overflow_flag = overflow_r;
  assign overrun_flag = overrun_r;
  assign timer_irq_flag = timer_irq_r;
endmodule

// *** verification/daqreg_bank_sva.sv ***
// Port-level assertions for the DAQ register bank.
`timescale 1ns/100ps
module daqreg_bank_sva import daqreg_pkg::*; (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic [4:0] bus_addr,
  input wire logic [7:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  input wire logic [15:0] bus_rdata,
  input wire logic adc_valid,
  input wire logic [11:0] adc_data,
  input wire logic adc_ready,
  input wire logic adc_busy,
  input wire logic conv_start,
  input wire logic [2:0] counter_clk,
  input wire logic [2:0] counter_gate,
  input wire logic [2:0] counter_out,
  input wire logic data_available_flag,
  input wire logic overflow_flag,
  input wire logic overrun_flag,
  input wire logic timer_irq_flag
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  wire clr_w = bus_wr && bus_addr == OFS_ACQ_CLEAR;
  wire irqc_w = bus_wr && bus_addr == OFS_TIMER_IRQ_CLEAR;
  wire fifo_rd = bus_rd && bus_addr == OFS_RESULT_FIFO;
  wire cnt_rd = bus_rd && bus_addr[4:2] == 3'h2 && bus_addr != 5'h0B;
  logic [3:0] c2_hist_r;
  wire [4:0] c2_seen = {c2_hist_r, counter_out[2]};
  // A rise just before the clear may still set the flag, so skip those.
  wire c2_quiet = (&c2_seen) || !(|c2_seen);
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset)
      c2_hist_r <= 4'hF;
    else
      c2_hist_r <= c2_seen[3:0];
  end
  sequence s_clear;
    clr_w && !adc_valid && !adc_busy && !conv_start
      && $stable(counter_out[0]);
  endsequence
  sequence s_refill;
    ##[1:3] data_available_flag;
  endsequence
  a_conv_pulse: assert property (conv_start |=> !conv_start)
    else $error("conv_start longer than one cycle");
  a_conv_cause: assert property (
    $rose(counter_out[0]) |-> ##[0:2] conv_start)
    else $error("no conversion start after counter 0 rise");
  a_clear_errors: assert property (
    s_clear |=> !overflow_flag && !overrun_flag)
    else $error("error flags survive a clear");
  a_clear_refill: assert property (s_clear |-> s_refill)
    else $error("no data after clear");
  a_irq_raise: assert property (
    $rose(counter_out[2]) |-> ##[1:3] timer_irq_flag)
    else $error("counter 2 rise did not raise request");
  a_irq_clear: assert property (
    irqc_w && c2_quiet |=> !timer_irq_flag)
    else $error("timer request not cleared");
  a_err_sticky: assert property (
    overflow_flag && !clr_w |=> overflow_flag)
    else $error("overflow flag dropped without clear");
  a_rdata_hold: assert property (!bus_rd |=> $stable(bus_rdata))
    else $error("read data changed without a read");
  a_cnt_high: assert property (
    cnt_rd |=> bus_rdata[15:8] == 8'h00)
    else $error("counter read has upper byte set");
  a_sign_ext: assert property (
    fifo_rd && data_available_flag
      |=> bus_rdata[15:11] == 5'h00 || bus_rdata[15:11] == 5'h1F)
    else $error("result word not sign extended");
  a_push_avail: assert property (
    adc_valid && adc_ready |-> ##[1:4] data_available_flag)
    else $error("stored word not flagged");
endmodule
bind daqreg_bank daqreg_bank_sva u_daqreg_bank_sva (.sys_clk, .reset,
  .bus_addr, .bus_wdata, .bus_wr, .bus_rd, .bus_rdata, .adc_valid,
  .adc_data, .adc_ready, .adc_busy, .conv_start, .counter_clk,
  .counter_gate, .counter_out, .data_available_flag, .overflow_flag,
  .overrun_flag, .timer_irq_flag);

// *** verification/adc_model.sv ***
// Converter model answering start pulses and words injected by the bench.
`timescale 1ns/100ps
module adc_model (
  input wire logic sys_clk,
  input wire logic conv_start,
  input wire logic hold_busy,
  input wire logic inj,
  input wire logic [11:0] inj_data,
  output logic adc_valid,
  output logic [11:0] adc_data,
  output logic adc_busy
);
  logic [2:0] busy_cnt = 3'h0;
  logic [11:0] seq = 12'h5A0;
  initial adc_valid = 1'b0;
  initial adc_data = 12'h000;
  assign adc_busy = hold_busy || busy_cnt != 3'h0;
  // Idle data toggles so a stale word is never taken for a result.
  always @(posedge sys_clk) begin
    adc_valid <= #1 inj || busy_cnt == 3'h1;
    if (inj)
      adc_data <= #1 inj_data;
    else if (busy_cnt == 3'h1) begin
      adc_data <= #1 seq;
      seq <= seq + 12'h001;
    end else
      adc_data <= #1 ~adc_data;
    if (conv_start && busy_cnt == 3'h0)
      busy_cnt <= #1 3'h4;
    else if (busy_cnt != 3'h0)
      busy_cnt <= #1 busy_cnt - 3'h1;
  end
endmodule

// *** verification/daqreg_bank_tb.sv ***
// Self-checking bench for the DAQ register bank.
`timescale 1ns/100ps
module daqreg_bank_tb;
  import daqreg_pkg::*;
  logic sys_clk = 0, reset = 1, bus_wr = 0, bus_rd = 0;
  logic hold_busy = 0, inj = 0, seen = 0;
  logic [4:0] bus_addr = 5'h00;
  logic [7:0] bus_wdata = 8'h00;
  logic [11:0] inj_data = 12'h000, adc_data;
  logic [2:0] counter_clk = 3'h0, counter_gate = 3'h7, counter_out;
  logic [15:0] bus_rdata, v;
  logic adc_valid, adc_ready, adc_busy, conv_start, data_available_flag;
  logic overflow_flag, overrun_flag, timer_irq_flag;
  int bad_count = 0, samples_checked = 0, cyc = 0;
  daqreg_bank u_daqreg_bank (.sys_clk, .reset, .bus_addr, .bus_wdata,
    .bus_wr, .bus_rd, .bus_rdata, .adc_valid, .adc_data, .adc_ready,
    .adc_busy, .conv_start, .counter_clk, .counter_gate, .counter_out,
    .data_available_flag, .overflow_flag, .overrun_flag, .timer_irq_flag);
  adc_model m_adc (.sys_clk, .conv_start, .hold_busy, .inj, .inj_data,
    .adc_valid, .adc_data, .adc_busy);
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (conv_start === 1'b1)
      seen = 1'b1;
    // Whole run needs under 4000 cycles; a hang ends here.
    if (cyc == 20000) begin
      bad_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic step(int n = 1);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic chkb(string name, logic exp, logic got);
    chk(name, {15'h0000, exp}, {15'h0000, got});
  endtask
  function automatic logic [15:0] sx(logic [11:0] x);
    return {{4{x[11]}}, x};
  endfunction
  task automatic wr(logic [4:0] a, logic [7:0] d);
    bus_addr = a;
    bus_wdata = d;
    bus_wr = 1'b1;
    step();
    bus_wr = 1'b0;
    step();
  endtask
  task automatic rd(logic [4:0] a, output logic [15:0] q);
    bus_addr = a;
    bus_rd = 1'b1;
    step();
    bus_rd = 1'b0;
    step(2);
    q = bus_rdata;
  endtask
  task automatic push(int n, logic [11:0] base);
    inj = 1'b1;
    for (int i = 0; i < n; i++) begin
      inj_data = base + 12'(i);
      step();
    end
    inj = 1'b0;
    step(6);
  endtask
  task automatic rise(int ch, int n);
    repeat (n) begin
      counter_clk[ch] = 1'b1;
      step(2);
      counter_clk[ch] = 1'b0;
      step(2);
    end
  endtask
  task automatic flush();
    wr(OFS_ACQ_CLEAR, 8'h00);
    rd(OFS_RESULT_FIFO, v);
  endtask
  task automatic t_clear();
    push(3, 12'h7FF);
    wr(OFS_ACQ_CLEAR, 8'h00);
    step();
    chkb("avail", 1'b1, data_available_flag);
    rd(OFS_RESULT_FIFO, v);
    chk("reload", sx(12'h801), v);
    chkb("empty", 1'b0, data_available_flag);
    rd(5'h1F, v);
    chk("unmapped", 16'h0000, v);
    rd(OFS_COUNTER_MODE, v);
    chk("mode rd", 16'h0000, v);
    $display("clear test done");
  endtask
  task automatic t_counter();
    wr(OFS_COUNTER_MODE, 8'h34);
    wr(OFS_COUNTER0_DATA, 8'h05);
    wr(OFS_COUNTER0_DATA, 8'h00);
    rise(0, 3);
    wr(OFS_COUNTER_MODE, 8'h00);
    rise(0, 1);
    rd(OFS_COUNTER0_DATA, v);
    chk("latch lo", 16'h0003, v);
    rd(OFS_COUNTER0_DATA, v);
    chk("latch hi", 16'h0000, v);
    wr(OFS_COUNTER_MODE, 8'hC2);
    rd(OFS_COUNTER0_DATA, v);
    chk("rb lo", 16'h0002, v);
    rd(OFS_COUNTER0_DATA, v);
    chk("rb hi", 16'h0000, v);
    seen = 1'b0;
    rise(0, 12);
    step(8);
    chkb("start", 1'b1, seen);
    chkb("conv avail", 1'b1, data_available_flag);
    hold_busy = 1'b1;
    rise(0, 12);
    hold_busy = 1'b0;
    chkb("overrun", 1'b1, overrun_flag);
    for (int m = 0; m < 6; m++)
      wr(OFS_COUNTER_MODE, {4'h7, 3'(m), m == 5});
    chkb("c1 mode5 out", 1'b1, counter_out[1]);
    step(10);
    flush();
    chkb("overrun clr", 1'b0, overrun_flag);
    $display("counter test done");
  endtask
  task automatic t_irq();
    wr(OFS_COUNTER_MODE, 8'h90);
    wr(OFS_COUNTER2_DATA, 8'h02);
    rise(2, 6);
    chkb("irq", 1'b1, timer_irq_flag);
    wr(OFS_TIMER_IRQ_CLEAR, 8'h00);
    chkb("irq clr", 1'b0, timer_irq_flag);
    $display("irq test done");
  endtask
  // Counter 1 in BCD from 0010: one step down must give 0009, not 000F.
  task automatic t_bcd();
    wr(OFS_COUNTER_MODE, 8'h71);
    chkb("c1 mode0 out", 1'b0, counter_out[1]);
    wr(OFS_COUNTER1_DATA, 8'h10);
    wr(OFS_COUNTER1_DATA, 8'h00);
    rise(1, 2);
    wr(OFS_COUNTER_MODE, 8'h40);
    rd(OFS_COUNTER1_DATA, v);
    chk("bcd lo", 16'h0009, v);
    rd(OFS_COUNTER1_DATA, v);
    chk("bcd hi", 16'h0000, v);
    rise(1, 9);
    chkb("c1 terminal", 1'b1, counter_out[1]);
    $display("bcd test done");
  endtask
  task automatic t_fill();
    int n;
    n = 0;
    push(530, 12'h7F0);
    chkb("overflow", 1'b1, overflow_flag);
    chkb("full ready", 1'b0, adc_ready);
    while (data_available_flag === 1'b1 && n < 600) begin
      rd(OFS_RESULT_FIFO, v);
      chk("word", sx(12'h7F0 + 12'(n)), v);
      n++;
    end
    chk("depth", 16'h0208, 16'(n));
    chkb("ready", 1'b1, adc_ready);
    // The last word offered was dropped, yet it is the newest conversion.
    wr(OFS_ACQ_CLEAR, 8'h00);
    rd(OFS_RESULT_FIFO, v);
    chk("last reload", sx(12'hA01), v);
    chkb("overflow clr", 1'b0, overflow_flag);
    chkb("avail clr", 1'b0, data_available_flag);
    $display("fill test done");
  endtask
  initial begin
    repeat (16) @(posedge sys_clk);
    #1;
    reset = 1'b0;
    t_clear();
    t_counter();
    t_irq();
    t_bcd();
    t_fill();
    complete_run();
  end
endmodule
